// File: test_trigger_sequencer_loop_control.sv
// Testbench for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module test_trigger_sequencer_loop_control;
  import trig_seq_pkg::*;
  localparam int SDEF = 20;
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic manualKey = 0, startOfTest = 0, measureDone, pready, pslverr;
  logic sourceStrobe, measureStrobe, busy;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] linkIn, linkOut, linkOutEn, fireLine = 4'h0;
  logic [4:0] measLag = 5'h0c;
  logic [31:0] cv [4] = '{32'h000204e2, 32'h000204e3, 32'h000009c4, 32'h000009c5};
  int pulseCnt, err_total = 0, n_compared = 0, seed = 66, nSrc = 0, n0, o, i;
  trigger_sequencer_loop_control #(.PULSE_LEN(PULSE_CYC), .SETTLE_DEF(SDEF)) dut_u (.mclk(mclk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkIn(linkIn), .linkOut(linkOut),
    .linkOutEn(linkOutEn), .manualKey(manualKey), .startOfTest(startOfTest), .measureDone(measureDone),
    .sourceStrobe(sourceStrobe), .measureStrobe(measureStrobe), .busy(busy));
  trig_link_partner far_u (.mclk(mclk), .fireLine(fireLine), .linkOut(linkOut), .linkOutEn(linkOutEn),
    .measureStrobe(measureStrobe), .measLag(measLag), .linkIn(linkIn), .measureDone(measureDone),
    .pulseCnt(pulseCnt));
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) nSrc += (sourceStrobe === 1'b1);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      chk(pready, 1);
      tally_and_finish();
    end
    rd = prdata;
    psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic waitBusy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim)
    begin
      @(posedge mclk);
      k++;
    end
    if (busy !== lvl)
    begin
      chk(busy, lvl);
      tally_and_finish();
    end
  endtask
  task automatic run(input logic [31:0] ctl, input int exSrc, input int exPulse);
    int s0;
    int p0;
    s0 = nSrc;
    p0 = pulseCnt;
    apb(1, CTRL_OFF, ctl);
    waitBusy(1, 10);
    waitBusy(0, 20000);
    cyc(PULSE_CYC + 4);
    chk(nSrc - s0, exSrc);
    chk(pulseCnt - p0, exPulse);
  endtask
  task automatic fire(input int s);
    case (s)
      1: begin fireLine <= 4'h1; cyc(4); fireLine <= 4'h0; cyc(1); end
      3: begin apb(1, CTRL_OFF, 32'h4); cyc(20); chk(nSrc - n0, 0); manualKey <= 1; cyc(10); manualKey <= 0; end
      4: apb(1, CTRL_OFF, 32'h4);
      5, 6, 7: startOfTest <= ~startOfTest;
      default: ;
    endcase
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    cyc(8);
    sys_rst <= 0;
    rdchk(COUNT_OFF, 32'h00010001);
    rdchk(OUTER_OFF, 32'h400);
    rdchk(INNER_OFF, 32'h4010);
    rdchk(TDELAY_OFF, 0);
    rdchk(SDELAY_OFF, SDEF);
    rdchk(12'h0f0, 0);
    chk(linkOutEn, 4'hf);
    run(1, 1, 0);
    $display("defaults and single run done");
    for (int f = 0; f < 5; f++)
    begin
      o = 1 + $unsigned($random(seed)) % 3;
      i = 1 + $unsigned($random(seed)) % 4;
      measLag <= 5'd12 + 5'($unsigned($random(seed)) % 8);
      apb(1, COUNT_OFF, {o[15:0], i[15:0]});
      apb(1, INNER_OFF, 32'h4010 | (f < 3 ? 32'h100 << f : 0));
      apb(1, OUTER_OFF, 32'h400 | (f >= 3 ? 32'h10 << (f - 3) : 0));
      run(1, o * i, f < 3 ? o * i : o);
    end
    apb(1, INNER_OFF, 32'h4010);
    apb(1, OUTER_OFF, 32'h400);
    $display("loop counts and output flags done");
    for (int c = 0; c < 4; c++)
    begin
      apb(1, COUNT_OFF, cv[c]);
      rdchk(COUNT_OFF, c[0] ? cv[c - 1] : cv[c]);
      apb(0, STATUS_OFF, 0);
      chk(rd[ST_REJECT], c[0]);
    end
    apb(1, COUNT_OFF, 32'h00000005);
    apb(1, CTRL_OFF, 32'h1);
    cyc(150);
    apb(1, CTRL_OFF, 32'h2);
    waitBusy(0, 5);
    n0 = nSrc;
    cyc(100);
    chk(nSrc - n0, 0);
    apb(1, COUNT_OFF, 32'h00010001);
    $display("count limits and abort done");
    apb(1, TIMER_OFF, 32'd40);
    for (int s = 0; s < 8; s++)
    begin
      startOfTest <= (s == 5);
      apb(1, OUTER_OFF, 32'h400 | 32'(s));
      apb(1, CTRL_OFF, 32'h8);
      n0 = nSrc;
      apb(1, CTRL_OFF, 32'h1);
      cyc(30);
      chk(nSrc - n0, s == 0 || s == 2);
      fire(s);
      waitBusy(0, 2000);
      chk(nSrc - n0, 1);
    end
    apb(1, TIMER_OFF, 32'd200);
    apb(1, OUTER_OFF, 32'h402);
    apb(1, COUNT_OFF, 32'h00020001);
    n0 = nSrc;
    apb(1, CTRL_OFF, 32'h1);
    cyc(100);
    chk(nSrc - n0, 1);
    waitBusy(0, 2000);
    chk(nSrc - n0, 2);
    apb(1, COUNT_OFF, 32'h00010001);
    apb(1, OUTER_OFF, 32'h409);
    apb(1, INNER_OFF, 32'h4013);
    run(1, 1, 0);
    $display("outer event sources done");
    apb(1, OUTER_OFF, 32'h400);
    apb(1, INNER_OFF, 32'h4011);
    fire(1);
    cyc(5);
    apb(0, STATUS_OFF, 0);
    chk(rd[ST_PENDIN], 1);
    apb(1, CTRL_OFF, 32'h8);
    apb(0, STATUS_OFF, 0);
    chk(rd[ST_PENDIN], 0);
    n0 = nSrc;
    apb(1, CTRL_OFF, 32'h1);
    cyc(40);
    chk(nSrc - n0, 0);
    fire(1);
    waitBusy(0, 2000);
    chk(nSrc - n0, 1);
    apb(1, INNER_OFF, 32'h4010);
    apb(1, SWEEP_OFF, 32'h00010003);
    run(32'h21, 3, 0);
    rdchk(COUNT_OFF, 32'h00010001);
    apb(1, INNER_OFF, 32'h4711);
    apb(1, TDELAY_OFF, 32'h3);
    apb(1, CTRL_OFF, 32'h10);
    rdchk(INNER_OFF, 32'h4010);
    rdchk(TDELAY_OFF, 0);
    $display("inner link, clear and sweep done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: trig_link_partner.sv
// Far side model: link instrument and measure datapath
`timescale 1ns/1ps
`default_nettype none
module trig_link_partner (
  input  wire logic       mclk,
  input  wire logic [3:0] fireLine,
  input  wire logic [3:0] linkOut,
  input  wire logic [3:0] linkOutEn,
  input  wire logic       measureStrobe,
  input  wire logic [4:0] measLag,
  output logic      [3:0] linkIn,
  output logic            measureDone,
  output var int          pulseCnt
);
  logic [3:0] pullLow = 4'h0;
  logic       prevEn  = 1'b1;
  int         lag     = 0;
  // Pulled-up wired lines
  assign linkIn = ~pullLow & (linkOutEn | linkOut);
  initial measureDone = 1'b0;
  initial pulseCnt = 0;
  always @(posedge mclk)
  begin
    pullLow <= fireLine;
    prevEn <= linkOutEn[1];
    if (prevEn && !linkOutEn[1])
      pulseCnt <= pulseCnt + 1;
    if (measureStrobe)
      lag <= int'(measLag);
    else if (lag > 0)
      lag <= lag - 1;
    measureDone <= (lag == 1);
  end
endmodule
`default_nettype wire

// File: trig_seq_pkg.sv
// Package with constants, register map and types of the trigger sequencer
package trig_seq_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFF    = 12'h000;
  localparam logic [ADDR_W-1:0] OUTER_OFF   = 12'h004;
  localparam logic [ADDR_W-1:0] INNER_OFF   = 12'h008;
  localparam logic [ADDR_W-1:0] COUNT_OFF   = 12'h00c;
  localparam logic [ADDR_W-1:0] TIMER_OFF   = 12'h010;
  localparam logic [ADDR_W-1:0] TDELAY_OFF  = 12'h014;
  localparam logic [ADDR_W-1:0] SDELAY_OFF  = 12'h018;
  localparam logic [ADDR_W-1:0] STATUS_OFF  = 12'h01c;
  localparam logic [ADDR_W-1:0] SWEEP_OFF   = 12'h020;

  // CTRL command bits (write one to act)
  localparam int CMD_INIT  = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_BUSTRG = 2;
  localparam int CMD_CLEAR = 3;
  localparam int CMD_DEFAULT = 4;
  localparam int CMD_SWEEP = 5;

  // OUTER register fields
  localparam int OSRC_LSB   = 0;   // 3 bits
  localparam int ODIR_BIT   = 3;
  localparam int OENTER_BIT = 4;
  localparam int OLEAVE_BIT = 5;
  localparam int OIN_LSB    = 8;   // 2 bits
  localparam int OOUT_LSB   = 10;  // 2 bits
  // INNER register fields
  localparam int ISRC_BIT   = 0;
  localparam int IDIR_BIT   = 1;
  localparam int IDET_LSB   = 4;   // source, delay, measure
  localparam int IOUT_LSB   = 8;   // source, delay, measure
  localparam int IIN_LSB    = 12;
  localparam int IOUTL_LSB  = 14;
  // COUNT register: inner low 16, outer high 16; outer zero is infinite
  localparam int CNT_W      = 16;
  localparam int BUF_CAP    = 2500;

  // STATUS bits
  localparam int ST_BUSY    = 0;
  localparam int ST_REJECT  = 1;
  localparam int ST_PENDOUT = 2;
  localparam int ST_PENDIN  = 3;
  localparam int ST_STATE_LSB = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ       = 10_000_000;
  localparam int SETTLE_US    = 1000;   // 0.001 sec
  localparam int SETTLE_CYC   = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_CYC    = 10;
  localparam int LINE_W       = 2;
  localparam logic [LINE_W-1:0] IN_LINE_DEF  = 2'h0;  // line #1
  localparam logic [LINE_W-1:0] OUT_LINE_DEF = 2'h1;  // line #2

  // Outer event sources
  typedef enum logic [2:0] {
    SRC_IMM  = 3'h0,
    SRC_LINK = 3'h1,
    SRC_TIMER = 3'h2,
    SRC_MANUAL = 3'h3,
    SRC_BUS  = 3'h4,
    SRC_FSOT = 3'h5,
    SRC_RSOT = 3'h6,
    SRC_ESOT = 3'h7
  } outer_src_t;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_OUTER   = 8'h02,
    ST_SRC_DET = 8'h04,
    ST_TDELAY  = 8'h08,
    ST_SOURCE  = 8'h10,
    ST_DLY_DET = 8'h20,
    ST_SETTLE  = 8'h40,
    ST_MEASURE = 8'h80
  } seq_state_t;

endpackage

// File: trig_seq_sva.sv
// Port assertions for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module trig_seq_sva
  import trig_seq_pkg::*;
#(parameter int PULSE_LEN = PULSE_CYC)(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [3:0]        linkOut,
  input wire logic [3:0]        linkOutEn,
  input wire logic              sourceStrobe,
  input wire logic              measureStrobe,
  input wire logic              busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic ctlWr;
  int   lowCnt;
  assign ctlWr = psel && penable && pwrite && paddr == CTRL_OFF;
  // Length of the low phase on the default output line
  always_ff @(posedge mclk)
    if (sys_rst) lowCnt <= 0;
    else lowCnt <= linkOutEn[1] ? 0 : lowCnt + 1;
  a_apb_answer: assert property (psel && penable |-> pready && !pslverr) else $error("bus answer wrong");
  a_drive_low: assert property (linkOut == 4'h0) else $error("link drive level wrong");
  a_pulse_max: assert property (lowCnt <= PULSE_LEN) else $error("pulse too long");
  a_pulse_len: assert property ($rose(linkOutEn[1]) |-> lowCnt == PULSE_LEN) else $error("pulse length");
  a_abort_idle: assert property (ctlWr && pwdata[CMD_ABORT] |-> ##[1:3] !busy) else $error("abort ignored");
  a_init_busy: assert property (ctlWr && pwdata[CMD_INIT] && !pwdata[CMD_ABORT] && !busy |-> ##[1:3] busy)
    else $error("initiate ignored");
  a_action_order: assert property (sourceStrobe |=> !sourceStrobe && !measureStrobe)
    else $error("actions out of order");
  a_idle_quiet: assert property (!busy && !$past(busy) |-> !sourceStrobe) else $error("action in idle");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> linkOutEn == 4'hf && !busy)
    else $error("reset state wrong");
  c_pulse: cover property ($fell(linkOutEn[1]));
  c_abort: cover property (ctlWr && pwdata[CMD_ABORT] && busy);
  c_loop: cover property (sourceStrobe ##[1:200] sourceStrobe);
endmodule
bind trigger_sequencer_loop_control trig_seq_sva #(.PULSE_LEN(PULSE_LEN)) chk_u (.mclk(mclk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .linkOut(linkOut), .linkOutEn(linkOutEn),
  .sourceStrobe(sourceStrobe), .measureStrobe(measureStrobe), .busy(busy));
`default_nettype wire

// File: trigger_sequencer_loop_control.sv
// Two-layer trigger sequencer with APB registers and four-line trigger link
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module trigger_sequencer_loop_control
  import trig_seq_pkg::*;
#(
  parameter int PULSE_LEN  = PULSE_CYC,
  parameter int SETTLE_DEF = SETTLE_CYC
)(
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [trig_seq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [3:0]                linkIn,
  output logic      [3:0]                linkOut,
  output logic      [3:0]                linkOutEn,
  input  wire logic                      manualKey,
  input  wire logic                      startOfTest,
  input  wire logic                      measureDone,
  output logic                           sourceStrobe,
  output logic                           measureStrobe,
  output logic                           busy
);
  import trig_seq_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0]        outerSrc_reg;
  logic              outerDir_reg, enterEv_reg, leaveEv_reg;
  logic [LINE_W-1:0] outerInLine_reg, outerOutLine_reg, innerInLine_reg, innerOutLine_reg;
  logic              innerSrc_reg, innerDir_reg;
  logic [2:0]        innerDet_reg, innerOut_reg;
  logic [CNT_W-1:0]  outerCnt_reg, innerCnt_reg, savedOuter_reg, savedInner_reg;
  logic [CNT_W-1:0]  sweepOuter_reg, sweepInner_reg;
  logic              sweepActive_reg, reject_reg;
  logic [31:0]       timerIvl_reg, tDelay_reg, sDelay_reg;
  seq_state_t        state_reg, state_next;

  // Synchronisers and pending events
  logic [3:0] linkMeta_reg, linkSync_reg, linkPrev_reg, linkPend_reg;
  logic [1:0] sotMeta_reg, sotSync_reg;
  logic       sotPrev_reg, busPend_reg, timerDue_reg, firstPass_reg;
  logic [31:0] timerCnt_reg, waitCnt_reg;
  logic [CNT_W-1:0] outerDone_reg, innerDone_reg;
  logic [3:0]  pulseReq;
  logic [15:0] pulseCnt_reg [4];

  wire wr = psel && penable && pwrite;
  wire initCmd  = wr && paddr == CTRL_OFF && pwdata[CMD_INIT];
  wire abortCmd = wr && paddr == CTRL_OFF && pwdata[CMD_ABORT];
  wire busCmd   = wr && paddr == CTRL_OFF && pwdata[CMD_BUSTRG];
  wire clearCmd = wr && paddr == CTRL_OFF && pwdata[CMD_CLEAR];
  wire dfltCmd  = wr && paddr == CTRL_OFF && pwdata[CMD_DEFAULT];
  wire sweepCmd = wr && paddr == CTRL_OFF && pwdata[CMD_SWEEP];
  wire idle     = state_reg == ST_IDLE;

  // Finite product of counts must fit the reading buffer
  function automatic logic countsOk(input logic [CNT_W-1:0] o, input logic [CNT_W-1:0] i);
    logic [2*CNT_W-1:0] prod;
    prod = o * i;
    if (i == '0)
      countsOk = 1'b0;
    else if (o == '0)
      countsOk = i <= CNT_W'(BUF_CAP);
    else
      countsOk = prod <= (2*CNT_W)'(BUF_CAP);
  endfunction

  // ****************************************
  // APB slave, configuration
  // ****************************************
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || dfltCmd)
    begin
      outerSrc_reg     <= SRC_IMM;
      innerSrc_reg     <= 1'b0;
      outerDir_reg     <= 1'b0;
      innerDir_reg     <= 1'b0;
      enterEv_reg      <= 1'b0;
      leaveEv_reg      <= 1'b0;
      innerOut_reg     <= 3'h0;
      innerDet_reg     <= 3'h1;
      outerInLine_reg  <= IN_LINE_DEF;
      innerInLine_reg  <= IN_LINE_DEF;
      outerOutLine_reg <= OUT_LINE_DEF;
      innerOutLine_reg <= OUT_LINE_DEF;
      timerIvl_reg     <= 32'h1;
      tDelay_reg       <= 32'h0;
      sDelay_reg       <= 32'(SETTLE_DEF);
      sweepOuter_reg   <= CNT_W'(1);
      sweepInner_reg   <= CNT_W'(1);
    end
    else if (wr && idle)
    begin
      case (paddr)
        OUTER_OFF:
        begin
          outerSrc_reg     <= pwdata[OSRC_LSB+:3];
          outerDir_reg     <= pwdata[ODIR_BIT];
          enterEv_reg      <= pwdata[OENTER_BIT];
          leaveEv_reg      <= pwdata[OLEAVE_BIT];
          outerInLine_reg  <= pwdata[OIN_LSB+:LINE_W];
          outerOutLine_reg <= pwdata[OOUT_LSB+:LINE_W];
        end
        INNER_OFF:
        begin
          innerSrc_reg     <= pwdata[ISRC_BIT];
          innerDir_reg     <= pwdata[IDIR_BIT];
          innerDet_reg     <= pwdata[IDET_LSB+:3];
          innerOut_reg     <= pwdata[IOUT_LSB+:3];
          innerInLine_reg  <= pwdata[IIN_LSB+:LINE_W];
          innerOutLine_reg <= pwdata[IOUTL_LSB+:LINE_W];
        end
        TIMER_OFF:  timerIvl_reg <= pwdata;
        TDELAY_OFF: tDelay_reg <= pwdata;
        SDELAY_OFF: sDelay_reg <= pwdata;
        SWEEP_OFF:
        begin
          sweepInner_reg <= pwdata[CNT_W-1:0];
          sweepOuter_reg <= pwdata[2*CNT_W-1:CNT_W];
        end
        default: ;
      endcase
    end
  end

  // Loop counts, with checking and sweep save/restore
  always_ff @(posedge mclk)
  begin
    if (sys_rst || dfltCmd)
    begin
      outerCnt_reg    <= CNT_W'(1);
      innerCnt_reg    <= CNT_W'(1);
      savedOuter_reg  <= CNT_W'(1);
      savedInner_reg  <= CNT_W'(1);
      sweepActive_reg <= 1'b0;
      reject_reg      <= 1'b0;
    end
    else if (wr && idle && paddr == COUNT_OFF)
    begin
      if (countsOk(pwdata[2*CNT_W-1:CNT_W], pwdata[CNT_W-1:0]))
      begin
        innerCnt_reg <= pwdata[CNT_W-1:0];
        outerCnt_reg <= pwdata[2*CNT_W-1:CNT_W];
        reject_reg   <= 1'b0;
      end
      else
        reject_reg <= 1'b1;
    end
    else if (sweepCmd && idle && countsOk(sweepOuter_reg, sweepInner_reg))
    begin
      savedOuter_reg  <= outerCnt_reg;
      savedInner_reg  <= innerCnt_reg;
      outerCnt_reg    <= sweepOuter_reg;
      innerCnt_reg    <= sweepInner_reg;
      sweepActive_reg <= 1'b1;
    end
    else if (sweepActive_reg && !idle && state_next == ST_IDLE)
    begin
      outerCnt_reg    <= savedOuter_reg;
      innerCnt_reg    <= savedInner_reg;
      sweepActive_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        OUTER_OFF:  prdata <= {20'h0, outerOutLine_reg, outerInLine_reg, 2'h0, leaveEv_reg, enterEv_reg,
                               outerDir_reg, outerSrc_reg};
        INNER_OFF:  prdata <= {16'h0, innerOutLine_reg, innerInLine_reg, 1'b0, innerOut_reg, 1'b0,
                               innerDet_reg, 2'h0, innerDir_reg, innerSrc_reg};
        COUNT_OFF:  prdata <= {outerCnt_reg, innerCnt_reg};
        TIMER_OFF:  prdata <= timerIvl_reg;
        TDELAY_OFF: prdata <= tDelay_reg;
        SDELAY_OFF: prdata <= sDelay_reg;
        SWEEP_OFF:  prdata <= {sweepOuter_reg, sweepInner_reg};
        STATUS_OFF: prdata <= {16'h0, state_reg, 4'h0, |linkPend_reg, |pulseReq, reject_reg, !idle};
        default:    prdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Input synchronisers and event latches
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      linkMeta_reg <= 4'hf;
      linkSync_reg <= 4'hf;
      linkPrev_reg <= 4'hf;
      sotMeta_reg  <= 2'h0;
      sotSync_reg  <= 2'h0;
      sotPrev_reg  <= 1'b0;
    end
    else
    begin
      linkMeta_reg <= linkIn;
      linkSync_reg <= linkMeta_reg;
      linkPrev_reg <= linkSync_reg;
      sotMeta_reg  <= {manualKey, startOfTest};
      sotSync_reg  <= sotMeta_reg;
      sotPrev_reg  <= sotSync_reg[0];
    end
  end

  wire [3:0] linkFall = linkPrev_reg & ~linkSync_reg;
  wire sotFall = sotPrev_reg && !sotSync_reg[0];
  wire sotRise = !sotPrev_reg && sotSync_reg[0];
  logic [3:0] linkUse;
  logic outerPass, innerPass, outerTake;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || clearCmd)
      linkPend_reg <= 4'h0;
    else
      linkPend_reg <= (linkPend_reg & ~linkUse) | linkFall;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || clearCmd || abortCmd)
      busPend_reg <= 1'b0;
    else if (busCmd && outerSrc_reg == SRC_BUS && !idle)
      busPend_reg <= 1'b1;
    else if (outerTake)
      busPend_reg <= 1'b0;
  end

  // Outer timer: free-running while active, first pass immediate
  always_ff @(posedge mclk)
  begin
    if (sys_rst || idle)
    begin
      timerCnt_reg  <= 32'h0;
      timerDue_reg  <= 1'b0;
      firstPass_reg <= 1'b1;
    end
    else
    begin
      // Consumption first so a new elapse in the same cycle is kept
      if (outerTake)
      begin
        firstPass_reg <= 1'b0;
        timerDue_reg  <= 1'b0;
      end
      if (timerCnt_reg + 32'h1 >= timerIvl_reg)
      begin
        timerCnt_reg <= 32'h0;
        timerDue_reg <= 1'b1;
      end
      else
        timerCnt_reg <= timerCnt_reg + 32'h1;
    end
  end

  // Outer detector, with bypass only for link and start-of-test sources
  always_comb
  begin
    case (outerSrc_reg)
      SRC_IMM:    outerPass = 1'b1;
      SRC_LINK:   outerPass = linkPend_reg[outerInLine_reg];
      SRC_TIMER:  outerPass = firstPass_reg || timerDue_reg;
      SRC_MANUAL: outerPass = sotSync_reg[1];
      SRC_BUS:    outerPass = busPend_reg;
      SRC_FSOT:   outerPass = sotFall;
      SRC_RSOT:   outerPass = sotRise;
      default:    outerPass = sotFall || sotRise;
    endcase
    if (outerDir_reg && firstPass_reg && (outerSrc_reg == SRC_LINK || outerSrc_reg >= SRC_FSOT))
      outerPass = 1'b1;
    innerPass = !innerSrc_reg || linkPend_reg[innerInLine_reg];
  end

  // ****************************************
  // Sequencer
  // ****************************************
  wire innerLast = innerDone_reg + CNT_W'(1) >= innerCnt_reg;
  wire outerLast = outerCnt_reg != '0 && outerDone_reg + CNT_W'(1) >= outerCnt_reg;
  wire waitDone  = waitCnt_reg == 32'h0;
  wire srcBypass = innerDir_reg && innerDone_reg == '0;

  always_comb
  begin
    state_next = state_reg;
    outerTake  = 1'b0;
    linkUse    = 4'h0;
    pulseReq   = 4'h0;
    case (state_reg)
      ST_IDLE:
        if (initCmd)
          state_next = ST_OUTER;
      ST_OUTER:
        if (outerPass)
        begin
          outerTake  = 1'b1;
          state_next = ST_SRC_DET;
          if (outerSrc_reg == SRC_LINK)
            linkUse[outerInLine_reg] = 1'b1;
          if (enterEv_reg)
            pulseReq[outerOutLine_reg] = 1'b1;
        end
      ST_SRC_DET:
        if (!innerDet_reg[0] || srcBypass || innerPass)
        begin
          state_next = ST_TDELAY;
          if (innerSrc_reg && innerDet_reg[0] && !srcBypass)
            linkUse[innerInLine_reg] = 1'b1;
        end
      ST_TDELAY:
        if (waitDone)
          state_next = ST_SOURCE;
      ST_SOURCE:
      begin
        state_next = ST_DLY_DET;
        if (innerOut_reg[0])
          pulseReq[innerOutLine_reg] = 1'b1;
      end
      ST_DLY_DET:
        if (!innerDet_reg[1] || innerPass)
        begin
          state_next = ST_SETTLE;
          if (innerSrc_reg && innerDet_reg[1])
            linkUse[innerInLine_reg] = 1'b1;
        end
      ST_SETTLE:
        if (waitDone && (!innerDet_reg[2] || innerPass))
        begin
          state_next = ST_MEASURE;
          if (innerOut_reg[1])
            pulseReq[innerOutLine_reg] = 1'b1;
          if (innerSrc_reg && innerDet_reg[2])
            linkUse[innerInLine_reg] = 1'b1;
        end
      ST_MEASURE:
        if (measureDone)
        begin
          if (innerOut_reg[2])
            pulseReq[innerOutLine_reg] = 1'b1;
          if (!innerLast)
            state_next = ST_SRC_DET;
          else
          begin
            if (leaveEv_reg)
              pulseReq[outerOutLine_reg] = 1'b1;
            state_next = outerLast ? ST_IDLE : ST_OUTER;
          end
        end
      default: state_next = ST_IDLE;
    endcase
    if (abortCmd)
      state_next = ST_IDLE;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Loop counters and delay timers
  always_ff @(posedge mclk)
  begin
    if (sys_rst || state_next == ST_IDLE)
    begin
      innerDone_reg <= '0;
      outerDone_reg <= '0;
      waitCnt_reg   <= 32'h0;
    end
    else
    begin
      if (state_reg == ST_MEASURE && measureDone)
      begin
        innerDone_reg <= innerLast ? '0 : innerDone_reg + CNT_W'(1);
        if (innerLast)
          outerDone_reg <= outerDone_reg + CNT_W'(1);
      end
      if (state_next == ST_TDELAY && state_reg != ST_TDELAY)
        waitCnt_reg <= tDelay_reg;
      else if (state_next == ST_SETTLE && state_reg != ST_SETTLE)
        waitCnt_reg <= sDelay_reg;
      else if (!waitDone)
        waitCnt_reg <= waitCnt_reg - 32'h1;
    end
  end

  // ****************************************
  // Output trigger pulses, active low
  // ****************************************
  for (genvar g = 0; g < 4; g++)
  begin : gPulse
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        pulseCnt_reg[g] <= 16'h0;
      else if (pulseReq[g])
        pulseCnt_reg[g] <= 16'(PULSE_LEN);
      else if (pulseCnt_reg[g] != 16'h0)
        pulseCnt_reg[g] <= pulseCnt_reg[g] - 16'h1;
    end
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
      begin
        linkOut[g]   <= 1'b0;
        linkOutEn[g] <= 1'b1;
      end
      else
      begin
        linkOut[g]   <= 1'b0;
        linkOutEn[g] <= !(pulseReq[g] || pulseCnt_reg[g] > 16'h1);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sourceStrobe  <= 1'b0;
      measureStrobe <= 1'b0;
      busy          <= 1'b0;
    end
    else
    begin
      sourceStrobe  <= state_next == ST_SOURCE;
      measureStrobe <= state_next == ST_MEASURE && state_reg != ST_MEASURE;
      busy          <= state_next != ST_IDLE;
    end
  end

endmodule
`default_nettype wire
